// ### rtl/lnu_pkg.sv
// shared constants of the lin/uart byte service block
package lnu_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_ERROR = 4'h3;
	localparam logic [3:0] ADDR_BIT_TIMING = 4'h4;
	localparam logic [3:0] ADDR_BAUD_LOW = 4'h5;
	localparam logic [3:0] ADDR_BAUD_HIGH = 4'h6;
	localparam logic [3:0] ADDR_DATA_LENGTH = 4'h7;
	localparam logic [3:0] ADDR_IDENTIFIER = 4'h8;
	localparam logic [3:0] ADDR_BUF_SELECT = 4'h9;
	localparam logic [3:0] ADDR_DATA_PORT = 4'hA;
	localparam logic [3:0] ADDR_CHECKSUM = 4'hB;
	// controller_control fields
	localparam int CTL_SOFT_RESET = 7;
	localparam int CTL_UART_MODE = 6;
	localparam int CTL_PROTO_13 = 5;
	localparam int CTL_ENABLE = 4;
	localparam int CTL_CONF_HI = 3;
	localparam int CTL_CONF_LO = 2;
	localparam int CTL_RX_EN = 1;
	localparam int CTL_TX_EN = 0;
	// status_and_interrupt fields
	localparam int ST_RX_COMPLETE = 0;
	localparam int ST_TX_COMPLETE = 1;
	localparam int ST_BUSY = 4;
	// error_flags fields
	localparam int ERR_PARITY = 1;
	localparam int ERR_FRAMING = 2;
	localparam int ERR_OVERRUN = 3;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_BIT_TIMING = 8'h20;
	localparam logic [7:0] RST_IDENTIFIER = 8'h80;
	localparam logic [3:0] LOW_NIBBLE = 4'hF;
	localparam int SAMPLE_W = 6;
	localparam int BAUD_W = 12;
	typedef enum logic [1:0] {
		LNU_CONF_STD,
		LNU_CONF_OPT_A,
		LNU_CONF_OPT_B,
		LNU_CONF_LISTEN
	} lnu_conf_t;
	typedef enum logic [2:0] {
		LNU_SER_IDLE,
		LNU_SER_START,
		LNU_SER_DATA,
		LNU_SER_PARITY,
		LNU_SER_STOP
	} lnu_ser_t;
endpackage // lnu_pkg

// ### rtl/lnu_rx_shift.sv
// receive shift stage: serial to parallel conversion of one character
module lnu_rx_shift (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic enable,
	input wire logic rx_line,
	input wire logic tick,
	input wire logic [lnu_pkg::SAMPLE_W-1:0] samples,
	input wire logic parity_en,
	input wire logic parity_odd,
	output logic done,
	output logic [7:0] data,
	output logic frame_err,
	output logic parity_err,
	output logic active
);
	import lnu_pkg::*;
	lnu_ser_t state;
	logic [SAMPLE_W-1:0] samp;
	logic [2:0] bit_idx;
	logic par_acc;
	logic bit_end;
	logic half_end;

	assign bit_end = tick && (samp == samples - 6'h01);
	assign half_end = tick && (samp == {1'b0, samples[SAMPLE_W-1:1]});
	assign active = (state != LNU_SER_IDLE);

	// start is checked mid-bit so a glitch on the idle line is rejected
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rst_n || clear || !enable) begin
			state <= LNU_SER_IDLE;
			samp <= '0;
			bit_idx <= '0;
			par_acc <= 1'b0;
			data <= 8'h00;
			frame_err <= 1'b0;
			parity_err <= 1'b0;
		end else begin
			if (tick) begin
				samp <= bit_end ? '0 : samp + 6'h01;
			end
			unique case (state)
				LNU_SER_IDLE: begin
					samp <= '0;
					if (!rx_line) begin
						state <= LNU_SER_START;
					end
				end
				LNU_SER_START: begin
					if (half_end) begin
						samp <= '0;
						state <= rx_line ? LNU_SER_IDLE : LNU_SER_DATA;
						bit_idx <= '0;
						par_acc <= parity_odd;
					end
				end
				LNU_SER_DATA: begin
					if (bit_end) begin
						data <= {rx_line, data[7:1]};
						par_acc <= par_acc ^ rx_line;
						bit_idx <= bit_idx + 3'h1;
						if (bit_idx == 3'h7) begin
							state <= parity_en ? LNU_SER_PARITY : LNU_SER_STOP;
						end
					end
				end
				LNU_SER_PARITY: begin
					if (bit_end) begin
						parity_err <= par_acc ^ rx_line;
						state <= LNU_SER_STOP;
					end
				end
				LNU_SER_STOP: begin
					if (bit_end) begin
						frame_err <= !rx_line;
						if (!parity_en) begin
							parity_err <= 1'b0;
						end
						done <= 1'b1;
						state <= LNU_SER_IDLE;
					end
				end
			endcase
		end
	end
endmodule // lnu_rx_shift

// ### rtl/lnu_core.sv
// lin/uart byte services, register file, resets and frame configuration
module lnu_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [lnu_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic serial_rx_pin,
	output logic serial_tx_pin
);
	import lnu_pkg::*;
	logic [7:0] controller_control;
	logic [7:0] interrupt_enable;
	logic [7:0] error_flags;
	logic [7:0] bit_timing;
	logic [7:0] baud_divider_low;
	logic [7:0] baud_divider_high;
	logic [7:0] frame_data_length;
	logic [7:0] frame_identifier;
	logic [7:0] buffer_select;
	logic [7:0] holding;
	logic holding_full;
	logic rx_complete_flag;
	logic tx_complete_flag;
	logic [7:0] checksum;
	logic [BAUD_W-1:0] baud_cnt;
	logic tick;
	lnu_ser_t tx_state;
	logic [SAMPLE_W-1:0] tx_samp;
	logic [2:0] tx_idx;
	logic [7:0] tx_shift;
	logic tx_par;
	logic tx_line;
	logic tx_bit_end;
	logic rx_done;
	logic [7:0] rx_byte;
	logic rx_framing_error_flag;
	logic rx_perr;
	logic rx_active;
	logic rx_line;
	logic busy;
	logic soft_reset;
	logic enabled;
	logic uart_mode;
	logic listen;
	logic parity_en;
	logic rx_take;
	logic tx_take;
	logic rx_release;
	logic cks_on;
	lnu_conf_t conf;

	assign soft_reset = wr_en && (addr == ADDR_CONTROL) && wr_data[CTL_SOFT_RESET];
	assign enabled = controller_control[CTL_ENABLE];
	assign uart_mode = controller_control[CTL_UART_MODE];
	assign conf = lnu_conf_t'(controller_control[CTL_CONF_HI:CTL_CONF_LO]);
	// same listening scheme in both modes, whatever the protocol version
	assign listen = (conf == LNU_CONF_LISTEN);
	assign parity_en = uart_mode && (conf == LNU_CONF_OPT_A || conf == LNU_CONF_OPT_B);
	assign rx_line = listen ? tx_line : serial_rx_pin;
	assign busy = enabled && ((tx_state != LNU_SER_IDLE) || rx_active);
	assign rx_take = rx_done && controller_control[CTL_RX_EN];
	// a byte offered mid-transmission is dropped, there is no queue
	assign tx_take = wr_en && (addr == ADDR_DATA_PORT) && enabled
		&& controller_control[CTL_TX_EN] && (tx_state == LNU_SER_IDLE);
	assign rx_release = (rd_en && (addr == ADDR_DATA_PORT))
		|| (wr_en && (addr == ADDR_STATUS) && wr_data[ST_RX_COMPLETE]);
	assign tx_bit_end = tick && (tx_samp == bit_timing[SAMPLE_W-1:0] - 6'h01);
	// uart mode and the no-checksum option both keep the data bytes out of the checksum
	assign cks_on = !uart_mode && (conf != LNU_CONF_OPT_A);

	// shared sample tick from the 12-bit baud divider
	always_ff @(posedge clk) begin
		if (!rst_n || !enabled) begin
			baud_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (baud_cnt == '0);
			baud_cnt <= (baud_cnt == '0) ? {baud_divider_high[3:0], baud_divider_low}
				: baud_cnt - 12'h001;
		end
	end

	lnu_rx_shift u_rx_shift (
		.clk(clk),
		.rst_n(rst_n),
		.clear(soft_reset),
		.enable(enabled && controller_control[CTL_RX_EN]),
		.rx_line(rx_line),
		.tick(tick),
		.samples(bit_timing[SAMPLE_W-1:0]),
		.parity_en(parity_en),
		.parity_odd(conf == LNU_CONF_OPT_B),
		.done(rx_done),
		.data(rx_byte),
		.frame_err(rx_framing_error_flag),
		.parity_err(rx_perr),
		.active(rx_active)
	);

	// software-written configuration
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			controller_control <= RST_ZERO;
			bit_timing <= RST_BIT_TIMING;
			frame_data_length <= RST_ZERO;
			frame_identifier <= RST_IDENTIFIER;
		end else if (wr_en) begin
			unique case (addr)
				ADDR_CONTROL: controller_control <= wr_data;
				ADDR_BIT_TIMING: bit_timing <= wr_data;
				ADDR_DATA_LENGTH: frame_data_length <= wr_data;
				ADDR_IDENTIFIER: frame_identifier <= wr_data;
				default: ;
			endcase
		end
	end

	// soft reset keeps the baud divider and the upper nibbles unchanged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			baud_divider_low <= RST_ZERO;
			baud_divider_high <= RST_ZERO;
			interrupt_enable <= RST_ZERO;
			buffer_select <= RST_ZERO;
		end else if (soft_reset) begin
			interrupt_enable <= interrupt_enable & ~{4'h0, LOW_NIBBLE};
			buffer_select <= buffer_select & ~{4'h0, LOW_NIBBLE};
		end else if (wr_en) begin
			unique case (addr)
				ADDR_BAUD_LOW: baud_divider_low <= wr_data;
				ADDR_BAUD_HIGH: baud_divider_high <= wr_data;
				ADDR_IRQ_ENABLE: interrupt_enable <= wr_data;
				ADDR_BUF_SELECT: buffer_select <= wr_data;
				default: ;
			endcase
		end
	end

	// holding stage; a completing character wins over a same-cycle release
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			holding <= RST_ZERO;
			holding_full <= 1'b0;
			rx_complete_flag <= 1'b0;
			error_flags <= RST_ZERO;
		end else if (rx_take) begin
			holding <= rx_byte;
			holding_full <= 1'b1;
			rx_complete_flag <= 1'b1;
			error_flags <= RST_ZERO;
			error_flags[ERR_OVERRUN] <= holding_full && !rx_release;
			error_flags[ERR_FRAMING] <= rx_framing_error_flag;
			error_flags[ERR_PARITY] <= rx_perr;
		end else if (rx_release) begin
			holding_full <= 1'b0;
			rx_complete_flag <= 1'b0;
		end
	end

	// transmit-complete: set on end of stop bit, cleared by write or by software
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			tx_complete_flag <= 1'b0;
		end else if (tx_state == LNU_SER_STOP && tx_bit_end) begin
			tx_complete_flag <= 1'b1;
		end else if (tx_take) begin
			tx_complete_flag <= 1'b0;
		end else if (wr_en && addr == ADDR_STATUS && wr_data[ST_TX_COMPLETE]) begin
			tx_complete_flag <= 1'b0;
		end
	end

	// transmit shifter; it has no error outputs at all
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			tx_state <= LNU_SER_IDLE;
			tx_samp <= '0;
			tx_idx <= '0;
			tx_shift <= RST_ZERO;
			tx_par <= 1'b0;
			tx_line <= 1'b1;
		end else begin
			if (tick) begin
				tx_samp <= tx_bit_end ? '0 : tx_samp + 6'h01;
			end
			unique case (tx_state)
				LNU_SER_IDLE: begin
					tx_samp <= '0;
					tx_line <= 1'b1;
					if (tx_take) begin
						tx_shift <= wr_data;
						tx_par <= (conf == LNU_CONF_OPT_B);
						tx_state <= LNU_SER_START;
						tx_line <= 1'b0;
					end
				end
				LNU_SER_START: begin
					if (tx_bit_end) begin
						tx_line <= tx_shift[0];
						tx_idx <= '0;
						tx_state <= LNU_SER_DATA;
					end
				end
				LNU_SER_DATA: begin
					if (tx_bit_end) begin
						tx_par <= tx_par ^ tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_idx <= tx_idx + 3'h1;
						if (tx_idx == 3'h7) begin
							tx_state <= parity_en ? LNU_SER_PARITY : LNU_SER_STOP;
							tx_line <= parity_en ? (tx_par ^ tx_shift[0]) : 1'b1;
						end else begin
							tx_line <= tx_shift[1];
						end
					end
				end
				LNU_SER_PARITY: begin
					if (tx_bit_end) begin
						tx_line <= 1'b1;
						tx_state <= LNU_SER_STOP;
					end
				end
				LNU_SER_STOP: begin
					if (tx_bit_end) begin
						tx_state <= LNU_SER_IDLE;
					end
				end
			endcase
		end
	end

	// pin held recessive while listening, so the bus never sees us
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serial_tx_pin <= 1'b1;
		end else begin
			serial_tx_pin <= listen ? 1'b1 : tx_line;
		end
	end

	// running lin checksum, add with end-around carry
	function automatic logic [7:0] cks_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			checksum <= RST_ZERO;
		end else if (wr_en && addr == ADDR_IDENTIFIER) begin
			// enhanced seeds with the identifier, classic starts empty
			checksum <= controller_control[CTL_PROTO_13] ? RST_ZERO : wr_data;
		end else if (cks_on && tx_take) begin
			checksum <= cks_add(checksum, wr_data);
		end else if (cks_on && rx_take) begin
			checksum <= cks_add(checksum, rx_byte);
		end
	end

	// read port, data stands one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= RST_ZERO;
		end else if (rd_en) begin
			unique case (addr)
				ADDR_CONTROL: rd_data <= controller_control;
				ADDR_STATUS: rd_data <= {3'h0, busy, 2'h0, tx_complete_flag, rx_complete_flag};
				ADDR_IRQ_ENABLE: rd_data <= interrupt_enable;
				ADDR_ERROR: rd_data <= error_flags;
				ADDR_BIT_TIMING: rd_data <= bit_timing;
				ADDR_BAUD_LOW: rd_data <= baud_divider_low;
				ADDR_BAUD_HIGH: rd_data <= baud_divider_high;
				ADDR_DATA_LENGTH: rd_data <= frame_data_length;
				ADDR_IDENTIFIER: rd_data <= frame_identifier;
				ADDR_BUF_SELECT: rd_data <= buffer_select;
				ADDR_DATA_PORT: rd_data <= holding;
				ADDR_CHECKSUM: rd_data <= ~checksum;
				default: rd_data <= RST_ZERO;
			endcase
		end else begin
			rd_data <= RST_ZERO;
		end
	end

	chk_rx_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		rx_take && !soft_reset |=> rx_complete_flag && holding_full)
		else $error("receive-complete not set after character");
	chk_read_frees: assert property (@(posedge clk) disable iff (!rst_n)
		rd_en && addr == ADDR_DATA_PORT && !rx_take |=> !rx_complete_flag && !holding_full)
		else $error("data read did not free holding stage");
	chk_discard_frees: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en && addr == ADDR_STATUS && wr_data[ST_RX_COMPLETE] && !rx_take |=> !holding_full)
		else $error("flag clear did not free holding stage");
	chk_overrun_mark: assert property (@(posedge clk) disable iff (!rst_n)
		rx_take && holding_full && !rx_release && !soft_reset
		|=> error_flags[ERR_OVERRUN] && holding == $past(rx_byte))
		else $error("overrun not reported with overwriting character");
	chk_tx_start: assert property (@(posedge clk) disable iff (!rst_n)
		tx_take && !soft_reset |=> !tx_complete_flag && tx_state == LNU_SER_START && !tx_line)
		else $error("data write did not start transmission");
	chk_tx_done: assert property (@(posedge clk) disable iff (!rst_n)
		tx_state == LNU_SER_STOP && tx_bit_end && !soft_reset
		|=> tx_complete_flag && tx_state == LNU_SER_IDLE)
		else $error("transmit-complete missing at end of stop bit");
	chk_tx_no_queue: assert property (@(posedge clk) disable iff (!rst_n)
		tx_state != LNU_SER_IDLE && wr_en && addr == ADDR_DATA_PORT && !tx_bit_end && !soft_reset
		|=> $stable(tx_shift))
		else $error("byte accepted during transmission");
	chk_listen_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		listen ##1 listen |-> serial_tx_pin)
		else $error("tx pin driven in listening mode");
	chk_busy_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		rd_en && addr == ADDR_STATUS |=> rd_data[ST_BUSY] == $past(busy))
		else $error("busy flag does not mirror busy state");
	chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
		soft_reset |=> bit_timing == RST_BIT_TIMING && frame_identifier == RST_IDENTIFIER
			&& baud_divider_low == $past(baud_divider_low) && controller_control == RST_ZERO)
		else $error("soft reset values wrong");
endmodule // lnu_core

// ### verification/lnu_peer.sv
// remote uart node: drives the receive line and decodes the transmit line
module lnu_peer #(
	parameter int BIT_CLKS = 4
) (
	input wire logic clk,
	input wire logic serial_tx_pin,
	output logic serial_rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_byte;
	logic got_par;
	logic with_parity;
	int got_count;
	initial begin
		serial_rx_pin = 1'b1;
		got_byte = 8'h00;
		got_par = 1'b0;
		with_parity = 1'b0;
		got_count = 0;
	end
	// par 1 even, 2 odd; stop_lvl 0 breaks the frame on purpose
	task automatic send_char(input logic [7:0] b, input logic [1:0] par, input logic stop_lvl);
		logic [10:0] f;
		logic p;
		int n;
		p = (par == 2'h2) ? ~^b : ^b;
		f = (par != 2'h0) ? {stop_lvl, p, b, 1'b0} : {1'b1, stop_lvl, b, 1'b0};
		n = (par != 2'h0) ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			serial_rx_pin <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
		@(posedge clk);
		// idle gap so the receiver has finished its stop bit before the next start
		serial_rx_pin <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
	endtask
	// samples mid-bit; reads the parity slot into got_par, then steps over the stop bit when parity is on
	always begin
		@(negedge serial_tx_pin);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			got_byte[i] = serial_tx_pin;
		end
		repeat (BIT_CLKS) @(posedge clk);
		got_par = serial_tx_pin;
		if (with_parity) repeat (BIT_CLKS) @(posedge clk);
		got_count++;
	end
endmodule // lnu_peer

// ### verification/tb.sv
// self-checking bench for the lin/uart byte service block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lnu_pkg::*;
	typedef logic [4:0][7:0] lnu_tb_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic serial_rx_pin;
	logic serial_tx_pin;
	logic [7:0] txb [3] = '{8'hA6, 8'h3B, 8'hC1};
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	int low_cnt = 0;
	int seen = 0;
	// addr, core reset, written, read back, after soft reset
	lnu_tb_row_t rows [10] = '{
		{8'h02, 8'h00, 8'hA5, 8'hA5, 8'hA0},
		{8'h05, 8'h00, 8'h3C, 8'h3C, 8'h3C},
		{8'h06, 8'h00, 8'h05, 8'h05, 8'h05},
		{8'h04, 8'h20, 8'h04, 8'h04, 8'h20},
		{8'h07, 8'h00, 8'h66, 8'h66, 8'h00},
		{8'h08, 8'h80, 8'h2A, 8'h2A, 8'h80},
		{8'h09, 8'h00, 8'h5C, 8'h5C, 8'h50},
		{8'h03, 8'h00, 8'hFF, 8'h00, 8'h00},
		{8'h01, 8'h00, 8'h00, 8'h00, 8'h00},
		{8'h0C, 8'h00, 8'h77, 8'h00, 8'h00}
	};
	lnu_core dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .serial_rx_pin(serial_rx_pin),
		.serial_tx_pin(serial_tx_pin));
	lnu_peer #(.BIT_CLKS(4)) peer (.clk(clk), .serial_tx_pin(serial_tx_pin),
		.serial_rx_pin(serial_rx_pin));
	always #50 clk = ~clk;
	task automatic wrap_up();
		if (fail_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ceiling well above the roughly 800 cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (serial_tx_pin !== 1'b1) low_cnt <= low_cnt + 1;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		d = rd_data;
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk8(d, exp);
	endtask
	task automatic sweep(input int sel);
		for (int i = 0; i < 10; i++) rdc(rows[i][4][ADDR_W-1:0], rows[i][sel]);
	endtask
	// bounded status poll; a flag that never comes shows up as a mismatch
	task automatic poll(input logic [7:0] mask);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < 60 && (d & mask) !== mask; i++) rd(ADDR_STATUS, d);
		if ((d & mask) !== mask) chk8(d, mask);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		sweep(3);
		for (int i = 0; i < 10; i++) wr(rows[i][4][ADDR_W-1:0], rows[i][2]);
		sweep(1);
		wr(ADDR_CONTROL, 8'h13);
		wr(ADDR_CONTROL, 8'h80);
		sweep(0);
		rdc(ADDR_CONTROL, 8'h00);
		wr(ADDR_BAUD_LOW, 8'h00);
		wr(ADDR_BAUD_HIGH, 8'h00);
		wr(ADDR_BIT_TIMING, 8'h04);
		// each parity setting; the second write lands while busy and must vanish
		for (int c = 0; c < 3; c++) begin
			seen = peer.got_count;
			peer.with_parity = (c != 0);
			wr(ADDR_CONTROL, 8'h53 | 8'(c << 2));
			wr(ADDR_DATA_PORT, txb[c]);
			wr(ADDR_DATA_PORT, 8'hFF);
			rdc(ADDR_STATUS, 8'h10);
			poll(8'h02);
			rdc(ADDR_STATUS, 8'h02);
			chk8(8'(peer.got_count - seen), 8'h01);
			chk8(peer.got_byte, txb[c]);
			if (c != 0) chk8({7'h00, peer.got_par}, {7'h00, (c == 2) ^ (^txb[c])});
			rdc(ADDR_ERROR, 8'h00);
		end
		wr(ADDR_STATUS, 8'h02);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'h53);
		peer.send_char(8'h5A, 2'h0, 1'b1);
		poll(8'h01);
		rdc(ADDR_STATUS, 8'h01);
		rdc(ADDR_ERROR, 8'h00);
		rdc(ADDR_DATA_PORT, 8'h5A);
		rdc(ADDR_STATUS, 8'h00);
		peer.send_char(8'h11, 2'h0, 1'b1);
		peer.send_char(8'h22, 2'h0, 1'b1);
		poll(8'h01);
		rdc(ADDR_ERROR, 8'h08);
		rdc(ADDR_DATA_PORT, 8'h22);
		peer.send_char(8'h44, 2'h0, 1'b1);
		poll(8'h01);
		wr(ADDR_STATUS, 8'h01);
		rdc(ADDR_STATUS, 8'h00);
		peer.send_char(8'h55, 2'h0, 1'b1);
		poll(8'h01);
		rdc(ADDR_ERROR, 8'h00);
		rdc(ADDR_DATA_PORT, 8'h55);
		peer.send_char(8'h66, 2'h0, 1'b0);
		poll(8'h01);
		rdc(ADDR_ERROR, 8'h04);
		rdc(ADDR_DATA_PORT, 8'h66);
		wr(ADDR_CONTROL, 8'h51);
		peer.send_char(8'h77, 2'h0, 1'b1);
		repeat (8) @(posedge clk);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'h5F);
		seen = peer.got_count;
		low_cnt = 0;
		wr(ADDR_DATA_PORT, 8'hC3);
		poll(8'h03);
		rdc(ADDR_STATUS, 8'h03);
		rdc(ADDR_DATA_PORT, 8'hC3);
		chk8(8'(low_cnt), 8'h00);
		chk8(8'(peer.got_count - seen), 8'h00);
		// lin checksum: enhanced seeds with the identifier, classic starts from zero
		wr(ADDR_CONTROL, 8'h13);
		wr(ADDR_IDENTIFIER, 8'h2A);
		rdc(ADDR_CHECKSUM, 8'hD5);
		wr(ADDR_CONTROL, 8'h33);
		wr(ADDR_IDENTIFIER, 8'h2A);
		rdc(ADDR_CHECKSUM, 8'hFF);
		wr(ADDR_DATA_PORT, 8'hF0);
		rdc(ADDR_CHECKSUM, 8'h0F);
		poll(8'h02);
		chk8(peer.got_byte, 8'hF0);
		wr(ADDR_CONTROL, 8'h37);
		wr(ADDR_IDENTIFIER, 8'h2A);
		wr(ADDR_DATA_PORT, 8'h11);
		rdc(ADDR_CHECKSUM, 8'hFF);
		poll(8'h02);
		chk8(peer.got_byte, 8'h11);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		sweep(3);
		wrap_up();
	end
endmodule // tb
